//--- common/nav_framer_pkg.sv
// constants, register map and types of the navigation message framer
package nav_framer_pkg;
  localparam int CLK_HZ       = 125_000_000;
  localparam int BIT_RATE_BPS = 50;
  localparam int FEC_DEN      = 2;
  localparam int SYM_RATE_SPS = BIT_RATE_BPS * FEC_DEN;
  localparam int SYM_CYCLES   = CLK_HZ / SYM_RATE_SPS;
  localparam int MSG_BITS     = 300;
  localparam int CRC_BITS     = 24;
  localparam int BODY_BITS    = MSG_BITS - CRC_BITS;
  localparam int MSG_SECONDS  = 6;
  localparam int EPH_TX_HOURS = 2;
  localparam int EPH_MSGS     = EPH_TX_HOURS * 3600 / MSG_SECONDS;
  localparam int TOW_WRAP     = 604800 / MSG_SECONDS;
  localparam logic [7:0] PREAMBLE  = 8'h8B;
  localparam logic [5:0] TYPE_DFLT = 6'h00;
  localparam logic [5:0] TYPE_EPH1 = 6'h0A;
  localparam logic [5:0] TYPE_EPH2 = 6'h0B;
  // first bit numbers of fields, bit 1 sent first
  localparam int F_PRE   = 1;
  localparam int F_ID    = 9;
  localparam int F_TYPE  = 15;
  localparam int F_TOW   = 21;
  localparam int F_ALERT = 38;
  localparam int F_FILL  = 39;
  localparam int F_WEEK  = 39;
  localparam int F_HLTH  = 52;
  localparam int F_ACC   = 66;
  localparam int F_TOE   = 71;
  localparam int F_INTEG = 272;
  localparam int F_PHASE = 273;
  localparam int FILL_BITS = BODY_BITS - F_FILL + 1;
  // register byte offsets
  localparam logic [7:0] R_CTRL   = 8'h00;
  localparam logic [7:0] R_TXID   = 8'h04;
  localparam logic [7:0] R_TOW    = 8'h08;
  localparam logic [7:0] R_EPH    = 8'h0C;
  localparam logic [7:0] R_COMMIT = 8'h10;
  localparam logic [7:0] R_STATUS = 8'h14;
  localparam logic [7:0] R_PAY    = 8'h20;
  localparam int PAY_WORDS = 8;
  // control and status bit positions
  localparam int C_RUN = 0;
  localparam int C_FAIL = 1;
  localparam int C_ALERT = 2;
  localparam int C_INTEG = 3;
  localparam int C_PHASE = 4;
  localparam int S_PEND = 0;
  localparam int S_STALE = 1;
  localparam int S_TOEERR = 2;
  localparam int S_SEND = 3;
  localparam int S_TYPE = 4;
  typedef enum logic {FR_IDLE, FR_SEND} fr_state_t;
  typedef struct packed {
    logic sym;
    logic sym_strobe;
    logic data_bit;
    logic bit_strobe;
    logic msg_start;
  } stream_t;
endpackage

//--- design/nav_message_framer.sv
// navigation message framer: apb registers, framing, crc, fec
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module nav_message_framer #(
  parameter int unsigned SYM_CYCLES = nav_framer_pkg::SYM_CYCLES,
  parameter int unsigned EPH_MSGS   = nav_framer_pkg::EPH_MSGS,
  parameter logic [23:0] CRC_POLY   = 24'h800063,
  parameter logic [6:0]  FEC_G1     = 7'h79,
  parameter logic [6:0]  FEC_G2     = 7'h5B
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output var  logic [31:0]             prdata,
  output var  logic                    pready,
  output var  logic                    pslverr,
  output var  nav_framer_pkg::stream_t tx
);
  if (SYM_CYCLES < 2 || SYM_CYCLES > 24'hFFFFFF) begin : g_chk_sym
    $error("SYM_CYCLES out of range");
  end
  if (EPH_MSGS < 1 || EPH_MSGS > 12'hFFF) begin : g_chk_eph
    $error("EPH_MSGS out of range");
  end

  typedef struct packed {
    nav_framer_pkg::fr_state_t st;
    logic                      run;
    logic                      fail;
    logic                      alert;
    logic                      integ;
    logic                      phase;
    logic [5:0]                txid;
    logic [16:0]               time_of_week_count;
    logic [12:0]               week;
    logic [2:0]                health;
    logic [4:0]                acc;
    logic [10:0]               toe;
    logic [7:0][31:0]          payload;
    logic                      pending;
    logic [5:0]                pend_type;
    logic                      stale;
    logic [11:0]               eph_age;
    logic                      toe_err;
    logic [275:0]              frame;
    logic [8:0]                bit_idx;
    logic                      half;
    logic [23:0]               cnt;
    logic [23:0]               crc;
    logic [5:0]                enc;
    logic                      cur_dflt;
    logic [5:0]                cur_type;
    logic [31:0]               prdata;
    logic                      pready;
    logic                      pslverr;
    nav_framer_pkg::stream_t   tx;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [23:0] crc_step(input logic [23:0] c,
                                           input logic b);
    crc_step = {c[22:0], 1'b0} ^ ((c[23] ^ b) ? CRC_POLY : 24'h000000);
  endfunction

  function automatic logic [16:0] tow_next(input logic [16:0] t);
    tow_next = (t == 17'(nav_framer_pkg::TOW_WRAP - 1)) ?
               17'h00000 : t + 17'h00001;
  endfunction

  logic [275:0] fr;
  logic         dflt;
  logic [5:0]   mtype;
  logic         do_load;
  logic         bnd;
  logic         nb;
  logic [7:0]   wa;
  logic         acc_cyc;
  logic [255:0] pay_flat;

  always_comb begin
    fr       = '0;
    dflt     = 1'b0;
    mtype    = nav_framer_pkg::TYPE_DFLT;
    do_load  = 1'b0;
    nb       = 1'b0;
    wa       = paddr;
    pay_flat = s_q.payload;
    s_d      = s_q;
    s_d.tx.sym_strobe = 1'b0;
    s_d.tx.bit_strobe = 1'b0;
    s_d.tx.msg_start  = 1'b0;
    bnd = (s_q.cnt == 24'(SYM_CYCLES - 1));

    // symbol and bit timing
    unique case (s_q.st)
      nav_framer_pkg::FR_IDLE: begin
        s_d.cnt = 24'h000000;
        s_d.enc = 6'h00;
        if (s_q.run) begin
          do_load = 1'b1;
          s_d.st  = nav_framer_pkg::FR_SEND;
        end
      end
      nav_framer_pkg::FR_SEND: begin
        s_d.cnt = bnd ? 24'h000000 : s_q.cnt + 24'h000001;
        if (bnd) begin
          s_d.half          = ~s_q.half;
          s_d.tx.sym_strobe = 1'b1;
          if (s_q.half) begin
            s_d.enc = {s_q.enc[4:0], s_q.tx.data_bit};
            if (s_q.bit_idx == 9'(nav_framer_pkg::MSG_BITS - 1)) begin
              if (s_q.run) begin
                do_load = 1'b1;
              end else begin
                s_d.st = nav_framer_pkg::FR_IDLE;
              end
            end else begin
              s_d.bit_idx       = s_q.bit_idx + 9'h001;
              s_d.tx.bit_strobe = 1'b1;
              if (s_d.bit_idx < 9'(nav_framer_pkg::BODY_BITS)) begin
                nb        = s_q.frame[275];
                s_d.frame = {s_q.frame[274:0], 1'b0};
                s_d.crc   = crc_step(s_q.crc, nb);
              end else begin
                nb      = s_q.crc[23];
                s_d.crc = {s_q.crc[22:0], 1'b0};
              end
              s_d.tx.data_bit = nb;
            end
          end
        end
      end
    endcase

    // message assembly at the start of each slot
    if (do_load) begin
      dflt = !s_q.pending || s_q.fail;
      if ((s_q.pend_type == nav_framer_pkg::TYPE_EPH1 ||
           s_q.pend_type == nav_framer_pkg::TYPE_EPH2) && s_q.stale) begin
        dflt = 1'b1;
      end
      mtype = dflt ? nav_framer_pkg::TYPE_DFLT : s_q.pend_type;
      if (dflt) begin
        fr[nav_framer_pkg::FILL_BITS-1:0] = {119{2'b10}};
      end else begin
        fr[nav_framer_pkg::FILL_BITS-1:0] =
          pay_flat[255 -: nav_framer_pkg::FILL_BITS];
        if (mtype == nav_framer_pkg::TYPE_EPH1) begin
          fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_WEEK -: 13] =
            s_q.week;
          fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_HLTH -: 3] =
            s_q.health;
          fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_ACC -: 5] =
            s_q.acc;
          fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_TOE -: 11] =
            s_q.toe;
          fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_INTEG] =
            s_q.integ;
          fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_PHASE] =
            s_q.phase;
        end
      end
      fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_PRE -: 8] =
        nav_framer_pkg::PREAMBLE;
      fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_ID -: 6] =
        s_q.txid;
      fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_TYPE -: 6] =
        mtype;
      fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_TOW -: 17] =
        s_q.time_of_week_count;
      fr[nav_framer_pkg::BODY_BITS - nav_framer_pkg::F_ALERT] =
        s_q.alert;
      s_d.frame         = {fr[274:0], 1'b0};
      s_d.crc           = crc_step(24'h000000, fr[275]);
      s_d.tx.data_bit   = fr[275];
      s_d.tx.bit_strobe = 1'b1;
      s_d.tx.msg_start  = 1'b1;
      s_d.tx.sym_strobe = 1'b1;
      s_d.bit_idx       = 9'h000;
      s_d.half          = 1'b0;
      s_d.cnt           = 24'h000000;
      s_d.time_of_week_count           = tow_next(s_q.time_of_week_count);
      s_d.pending       = 1'b0;
      s_d.cur_dflt      = dflt;
      s_d.cur_type      = mtype;
      // age counts every slot, so the limit is wall time, not repeats
      if (!s_q.stale) begin
        if (s_q.eph_age == 12'(EPH_MSGS - 1)) begin
          s_d.stale = 1'b1;
        end else begin
          s_d.eph_age = s_q.eph_age + 12'h001;
        end
      end
    end

    // encoder output for the symbol that starts now
    if (s_d.tx.sym_strobe) begin
      s_d.tx.sym = s_d.half ?
        ^(FEC_G2 & {s_d.tx.data_bit, s_d.enc}) :
        ^(FEC_G1 & {s_d.tx.data_bit, s_d.enc});
    end

    // apb slave: one wait state, registers after the engine so that a
    // commit landing on a slot start stays pending for the next slot
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    acc_cyc = psel && penable && !s_q.pready;
    if (acc_cyc) begin
      s_d.pready = 1'b1;
      s_d.prdata = 32'h00000000;
      // the payload window is decoded in full so high addresses never alias
      if (wa[1:0] != 2'b00) begin
        s_d.pslverr = 1'b1;
      end else if (wa[7:5] == nav_framer_pkg::R_PAY[7:5]) begin
        if (pwrite) begin
          s_d.payload[3'(7 - int'(wa[4:2]))] = pwdata;
        end else begin
          s_d.prdata = s_q.payload[3'(7 - int'(wa[4:2]))];
        end
      end else begin
        unique case (wa)
          nav_framer_pkg::R_CTRL: begin
            if (pwrite) begin
              s_d.run   = pwdata[nav_framer_pkg::C_RUN];
              s_d.fail  = pwdata[nav_framer_pkg::C_FAIL];
              s_d.alert = pwdata[nav_framer_pkg::C_ALERT];
              s_d.integ = pwdata[nav_framer_pkg::C_INTEG];
              s_d.phase = pwdata[nav_framer_pkg::C_PHASE];
            end
            s_d.prdata[4:0] = {s_q.phase, s_q.integ, s_q.alert,
                               s_q.fail, s_q.run};
          end
          nav_framer_pkg::R_TXID: begin
            if (pwrite) begin
              s_d.txid = pwdata[5:0];
            end
            s_d.prdata[5:0] = s_q.txid;
          end
          nav_framer_pkg::R_TOW: begin
            if (pwrite) begin
              s_d.time_of_week_count = pwdata[16:0];
            end
            s_d.prdata[16:0] = s_q.time_of_week_count;
          end
          nav_framer_pkg::R_EPH: begin
            if (pwrite) begin
              if (pwdata[31:21] != s_q.toe) begin
                s_d.week    = pwdata[12:0];
                s_d.health  = pwdata[15:13];
                s_d.acc     = pwdata[20:16];
                s_d.toe     = pwdata[31:21];
                s_d.stale   = 1'b0;
                s_d.eph_age = 12'h000;
              end else if (pwdata[20:0] !=
                           {s_q.acc, s_q.health, s_q.week}) begin
                s_d.toe_err = 1'b1;
              end
            end
            s_d.prdata = {s_q.toe, s_q.acc, s_q.health, s_q.week};
          end
          nav_framer_pkg::R_COMMIT: begin
            if (pwrite) begin
              s_d.pending   = 1'b1;
              s_d.pend_type = pwdata[5:0];
            end
            s_d.prdata[5:0] = s_q.pend_type;
          end
          nav_framer_pkg::R_STATUS: begin
            // the only set is an orbit write, never in the same cycle
            if (pwrite && pwdata[nav_framer_pkg::S_TOEERR]) begin
              s_d.toe_err = 1'b0;
            end
            s_d.prdata[9:0] = {s_q.cur_type,
                               s_q.st == nav_framer_pkg::FR_SEND,
                               s_q.toe_err, s_q.stale, s_q.pending};
          end
          default: begin
            s_d.pslverr = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q          <= '0;
      s_q.st       <= nav_framer_pkg::FR_IDLE;
      s_q.stale    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata  = s_q.prdata;
  assign pready  = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign tx      = s_q.tx;

  // helper: crc over all 300 sent bits must come to zero
  logic [23:0] chk_q;
  logic        seen_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_q  <= 24'h000000;
      seen_q <= 1'b0;
    end else if (s_q.tx.bit_strobe) begin
      chk_q  <= crc_step(s_q.tx.msg_start ? 24'h000000 : chk_q,
                         s_q.tx.data_bit);
      seen_q <= seen_q | s_q.tx.msg_start;
    end
  end

  a_crc_residue: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.tx.msg_start && seen_q && $past(s_q.st) == nav_framer_pkg::FR_SEND)
    |-> chk_q == 24'h000000)
    else $error("message crc residue not zero");
  a_preamble_lead: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tx.msg_start |-> s_q.tx.data_bit && s_q.bit_idx == 9'h000 &&
    s_q.frame[275:269] == 7'h0B)
    else $error("message does not open with preamble");
  a_sym_period: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tx.sym_strobe && !s_q.tx.msg_start |->
    $past(s_q.cnt) == 24'(SYM_CYCLES - 1))
    else $error("symbol period wrong");
  a_bit_two_syms: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tx.bit_strobe |-> s_q.tx.sym_strobe && !s_q.half)
    else $error("bit does not start on first symbol");
  a_fec_second: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tx.sym_strobe && s_q.half |->
    s_q.tx.sym == ^(FEC_G2 & {s_q.tx.data_bit, s_q.enc}))
    else $error("second symbol parity wrong");
  a_msg_length: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tx.bit_strobe && !s_q.tx.msg_start |->
    s_q.bit_idx == $past(s_q.bit_idx) + 9'h001 &&
    s_q.bit_idx < 9'(nav_framer_pkg::MSG_BITS))
    else $error("message length broken");
  a_default_fill: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.st == nav_framer_pkg::FR_SEND && s_q.cur_dflt &&
    s_q.bit_idx >= 9'd38 && s_q.bit_idx <= 9'd275 |->
    s_q.tx.data_bit == !s_q.bit_idx[0])
    else $error("default fill pattern wrong");
  a_default_type: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tx.msg_start && ($past(s_q.fail) || !$past(s_q.pending)) |->
    s_q.cur_dflt && s_q.cur_type == nav_framer_pkg::TYPE_DFLT)
    else $error("default message not substituted");
  a_stale_orbit: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.tx.msg_start && (s_q.cur_type == nav_framer_pkg::TYPE_EPH1 ||
    s_q.cur_type == nav_framer_pkg::TYPE_EPH2) |-> !$past(s_q.stale))
    else $error("stale orbit data broadcast");
  a_toe_refuse: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !s_q.pready && pwrite &&
    paddr == nav_framer_pkg::R_EPH && pwdata[31:21] == s_q.toe &&
    pwdata[20:0] != {s_q.acc, s_q.health, s_q.week} |=>
    s_q.toe_err && $stable(s_q.week))
    else $error("orbit change without new reference time");
endmodule // nav_message_framer
`default_nettype wire

//--- test/nav_rx_model.sv
// receiver model: collects messages, checks crc, fec and bit spacing
`timescale 1ns/1ps
`default_nettype none
module nav_rx_model #(
  parameter int unsigned SYM_CYCLES = 4,
  parameter logic [23:0] CRC_POLY   = 24'h800063,
  parameter logic [6:0]  FEC_G1     = 7'h79,
  parameter logic [6:0]  FEC_G2     = 7'h5B
) (
  input  wire logic                    pclk,
  input  wire nav_framer_pkg::stream_t tx,
  output var  logic [299:0]            msg_q,
  output var  int                      n_msg,
  output var  int                      n_bad,
  output var  int                      n_rsvd
);
  logic [299:0] sh;
  logic [23:0]  crc;
  logic [5:0]   hist;
  logic         cur;
  logic         seen;
  int           nbit;
  int           gap;
  int           sgap;
  // defined type codes; any other code is reserved
  function automatic logic known_type(input logic [5:0] t);
    known_type = t == 6'h00 || (t >= 6'h0A && t <= 6'h0F) ||
                 (t >= 6'h1E && t <= 6'h25);
  endfunction
  // behavioural on purpose: one process with blocking updates keeps the
  // checks in order and gives every variable a single writer
  initial begin
    {sh, msg_q, crc, hist, cur, seen} = '0;
    {n_msg, n_bad, n_rsvd, nbit, gap, sgap} = '0;
    forever begin
      @(posedge pclk);
      gap++;
      sgap++;
      if (tx.sym_strobe) begin
        if (tx.bit_strobe) begin
          if (seen && gap != 2 * SYM_CYCLES) n_bad++;
          gap = 0;
          cur = tx.data_bit;
          if (tx.sym !== ^({cur, hist} & FEC_G1)) n_bad++;
          if (tx.msg_start) begin
            // frames found by their start, 300 bits apart
            if (seen && nbit != 300) n_bad++;
            nbit = 0;
            crc = '0;
          end
          nbit++;
          sh = {sh[298:0], cur};
          crc = {crc[22:0], 1'b0} ^ ((crc[23] ^ cur) ? CRC_POLY : 24'h0);
          if (nbit == 300) begin
            if (crc !== 24'h0) n_bad++;
            // a reserved type is counted, and its message still goes out on msg_q
            if (!known_type(sh[285:280])) n_rsvd++;
            msg_q = sh;
            n_msg++;
          end
        end else begin
          if (tx.sym !== ^({cur, hist} & FEC_G2)) n_bad++;
          // newest bit at the low end, as the encoder keeps it
          hist = {hist[4:0], cur};
        end
        if (seen && sgap != SYM_CYCLES) n_bad++;
        sgap = 0;
        seen = 1'b1;
      end
    end
  end
endmodule // nav_rx_model
`default_nettype wire

//--- test/nav_message_framer_tb_top.sv
// testbench of the navigation message framer
`timescale 1ns/1ps
`default_nettype none
module nav_message_framer_tb_top;
  localparam int unsigned SYMC = 4;
  localparam int unsigned EPHM = 6;
  localparam logic [5:0]  TXID = 6'h2D;
  typedef struct packed {
    logic [4:0]  ctrl;
    logic        cm;
    logic [5:0]  ty;
    logic [16:0] time_of_week_count;
    logic [5:0]  exp;
  } row_t;
  logic                    pclk, presetn, psel, penable, pwrite;
  logic                    pready, pslverr, err;
  logic [7:0]              paddr;
  logic [31:0]             pwdata, prdata, rd;
  logic [299:0]            msg;
  logic [255:0]            cat;
  nav_framer_pkg::stream_t tx;
  int                      n_msg, n_bad, n_rsvd, n_fail, n_checks;
  // ctrl, commit, type, tow, expected type
  row_t rows [6] = '{'{5'h05, 1'b1, 6'h0F, 17'h00010, 6'h0F},
                     '{5'h01, 1'b1, 6'h3F, 17'h00011, 6'h3F},
                     '{5'h01, 1'b0, 6'h00, 17'h00012, 6'h00},
                     '{5'h01, 1'b1, 6'h0C, 17'h00013, 6'h0C},
                     '{5'h03, 1'b1, 6'h1E, 17'h00014, 6'h00},
                     '{5'h01, 1'b1, 6'h0A, 17'h00015, 6'h00}};
  nav_message_framer #(.SYM_CYCLES(SYMC), .EPH_MSGS(EPHM)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx(tx));
  nav_rx_model #(.SYM_CYCLES(SYMC)) rx (
    .pclk(pclk), .tx(tx), .msg_q(msg), .n_msg(n_msg), .n_bad(n_bad),
    .n_rsvd(n_rsvd));
  always #4 pclk = ~pclk;
  function automatic logic [31:0] pay(input int i);
    pay = 32'h9E37_79B9 ^ {4{8'(i)}};
  endfunction
  // fields are read msb first, bit 1 of the message is msg[299]
  function automatic logic [31:0] fld(input int f, input int w);
    fld = '0;
    for (int i = 0; i < w; i++) fld = {fld[30:0], msg[300 - f - i]};
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_fill(input logic [237:0] g, input logic [237:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: message fill differs", $time);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: no bus answer", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_start();
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (tx.msg_start !== 1'b1 && k < 3000);
    if (tx.msg_start !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: no message start", $time);
    end
  endtask
  task automatic wait_done();
    int k, c;
    k = 0;
    c = n_msg;
    while (n_msg == c && k < 3000) begin
      @(posedge pclk);
      k++;
    end
    if (n_msg == c) begin
      n_fail++;
      $display("wrong value at %0t: no message received", $time);
    end
  endtask
  task automatic check_msg(input logic [5:0] ty, input logic [16:0] time_of_week_count,
                           input logic al);
    chk(fld(1, 8), 32'h0000_008B);
    chk(fld(9, 6), 32'(TXID));
    chk(fld(15, 6), 32'(ty));
    chk(fld(21, 17), 32'(time_of_week_count));
    chk(fld(38, 1), 32'(al));
    if (ty == 6'h00) chk_fill(msg[261:24], {119{2'b10}});
    else if (ty != 6'h0A) chk_fill(msg[261:24], cat[255:18]);
  endtask
  initial begin
    #(8 * 90000);
    n_fail++;
    stop_test();
  end
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {n_fail, n_checks} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h06, 32'hFFFF_FFFF);
    chk(32'(err), 32'h1);
    apb(1'b1, 8'h04, 32'(TXID));
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'(TXID));
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 8'h20 + 8'(4 * i), pay(i));
      cat[255 - 32 * i -: 32] = pay(i);
    end
    apb(1'b1, 8'h08, 32'h0000_0007);
    apb(1'b1, 8'h00, 32'h0000_0001);
    wait_done();
    check_msg(6'h00, 17'h00007, 1'b0);
    // settings land during one message and show in the next
    foreach (rows[i]) begin
      wait_start();
      apb(1'b1, 8'h00, {27'h0, rows[i].ctrl});
      apb(1'b1, 8'h08, 32'(rows[i].time_of_week_count));
      if (rows[i].cm) apb(1'b1, 8'h10, 32'(rows[i].ty));
      wait_start();
      wait_done();
      check_msg(rows[i].exp, rows[i].time_of_week_count, rows[i].ctrl[2]);
    end
    wait_start();
    apb(1'b1, 8'h0C, {11'h2A5, 5'h10, 3'h5, 13'h1FFF});
    apb(1'b1, 8'h00, 32'h0000_0009);
    apb(1'b1, 8'h08, 32'h0001_89BF);
    apb(1'b1, 8'h10, 32'h0000_000A);
    wait_start();
    wait_done();
    check_msg(6'h0A, 17'h189BF, 1'b0);
    chk(fld(39, 13), 32'h1FFF);
    chk(fld(52, 3), 32'h5);
    chk(fld(66, 5), 32'h10);
    chk(fld(71, 11), 32'h2A5);
    chk(fld(272, 2), 32'h2);
    wait_start();
    apb(1'b1, 8'h0C, {11'h2A5, 5'h03, 3'h0, 13'h0123});
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rd[2]), 32'h1);
    apb(1'b1, 8'h14, 32'h0000_0004);
    apb(1'b0, 8'h14, 32'h0);
    chk(32'(rd[2]), 32'h0);
    apb(1'b1, 8'h00, 32'h0000_0011);
    apb(1'b1, 8'h10, 32'h0000_000A);
    wait_start();
    wait_done();
    // two messages after 100799 the count has wrapped to 1
    check_msg(6'h0A, 17'h00001, 1'b0);
    chk(fld(39, 13), 32'h1FFF);
    chk(fld(272, 2), 32'h1);
    wait_done();
    repeat (6) wait_start();
    apb(1'b1, 8'h10, 32'h0000_000B);
    wait_start();
    wait_done();
    check_msg(6'h00, 17'h00009, 1'b0);
    wait_start();
    apb(1'b1, 8'h0C, {11'h2A6, 5'h03, 3'h0, 13'h0123});
    apb(1'b1, 8'h10, 32'h0000_000B);
    wait_start();
    wait_done();
    check_msg(6'h0B, 17'h0000B, 1'b0);
    chk(32'(n_bad), 32'h0);
    chk(32'(n_rsvd), 32'h1);
    // reset in mid message: the link falls silent, registers return home
    wait_start();
    repeat (5) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(32'(tx), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_0002);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule // nav_message_framer_tb_top
`default_nettype wire
